// file: rtl/byte_io_bus.sv
// Processor end of the party-line byte I/O bus: strobes, acknowledge, concurrent block
// transfers and external interrupt intake. Assumes single-cycle memory read and write
// ports and a register master on ref_clk; bus inputs are asynchronous and active low.
`timescale 1ns/1ps
`include "byte_io_consts.svh"

// How it works
// - Requests are answered with acknowledge; the requester returns its acknowledge byte.
// - Control byte: device number in bits 4..0, device order in bits 7..5.
// - Control, data-out and data-in strobes stay low four cycles, then rise.
// - Data output puts the byte, nine bits with spare option, beside data-out strobe.
// - Mode 3 removes teletype line current and makes no byte bus activity.
// - Ninth input bit goes to the transfer register spare bit and, in concurrent input, to memory write data.
// - Current address steps per byte; past end address a stop control byte goes out.
// - Device in concurrent mode asks each byte with the transfer request line.
// - Request seen: acknowledge, take byte, drop acknowledge, wait request release.
// - Concurrent input: data-in strobe, capture byte, store at current address.
// - Concurrent output: fetch byte at current address, drive with data-out strobe.
// - Interrupt request seen: acknowledge, read identity byte, drop acknowledge.
// - Interrupts are taken only between macro instructions; identity selects routine.
// - Three-bit mode register loads from command bits 6-4; six defined modes, codes 4 and 7 act as idle.
// - Input bus lines are active low, driven by open-collector devices.
// - Bus clock out runs at half the processor clock, 50 percent duty.
module byte_io_bus
  import byte_io_pkg::*;
#(
  parameter int SPARE_BIT = 0
) (
  input wire logic ref_clk, // Processor clock
  input wire logic rst_n, // Async reset
  input wire logic [3:0] addr, // Register index
  input wire logic [15:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd_en
  input wire logic insn_boundary, // Between macro instructions
  output logic irq_taken, // Pulse: identity captured
  output logic [5:0] irq_id, // Interrupter identity
  output logic [15:0] mem_addr, // Memory address
  output logic [8:0] mem_wdata, // Memory write data
  output logic mem_we, // Memory write pulse
  output logic mem_rd, // Memory read, data same cycle
  input wire logic [8:0] mem_rdata, // Memory read data
  input wire logic [8:0] in_bus_n, // Input bus, active low
  input wire logic ext_irq_req_n, // External interrupt request
  input wire logic xfer_request_n, // Concurrent transfer request
  input wire logic priority_return_n, // End of priority chain
  output logic [8:0] out_bus_n, // Output bus, active low
  output logic ctrl_byte_strobe_n, // Control output strobe
  output logic data_out_strobe_n, // Data output strobe
  output logic ack_strobe_n, // Acknowledge strobe
  output logic data_in_strobe_n, // Data input strobe
  output logic bus_clock_out_n, // Half-rate bus clock
  output logic priority_out_n, // Start of priority chain
  output logic tty_line_on // Teletype loop current
);
  localparam logic [8:0] DMASK = (SPARE_BIT != 0) ? 9'h1ff : 9'h0ff;
  localparam logic [2:0] LAST = `STROBE_CYCLES - 3'h1;

  if (SPARE_BIT < 0 || SPARE_BIT > 1) begin : g_bad_spare
    $error("SPARE_BIT must be 0 or 1");
  end

  // Three-stage input synchroniser; a bit moves once stages two and three agree
  logic [11:0] s1_reg, s2_reg, s3_reg, held_reg, held_next;
  in_lines_t live;

  always_comb
  begin
    held_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (held_reg & (s2_reg ^ s3_reg));
    live = in_lines_t'(held_next);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= `RST_LINES;
      s2_reg <= `RST_LINES;
      s3_reg <= `RST_LINES;
      held_reg <= `RST_LINES;
    end
    else
    begin
      s1_reg <= {ext_irq_req_n, xfer_request_n, priority_return_n, in_bus_n};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      held_reg <= held_next;
    end
  end

  logic irq_req, xfer_req, prio_ret;
  logic [8:0] in_data;
  assign irq_req = ~live.irq_n;
  assign xfer_req = ~live.xfer_n;
  assign prio_ret = ~live.prio_n;
  assign in_data = ~live.data_n & DMASK;

  eng_state_t state_reg, state_next;
  io_mode_t mode_reg, mode_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [8:0] xfer_reg, xfer_next;
  logic [7:0] ack_reg, ack_next;
  logic [15:0] cur_reg, cur_next, end_reg, end_next, rdata_reg, rdata_next;
  logic conc_en_reg, conc_en_next, irq_en_reg, irq_en_next, prio_en_reg, prio_en_next;
  logic [2:0] stop_reg, stop_next;
  logic [5:0] irq_id_reg, irq_id_next;
  logic irq_pend_reg, irq_pend_next, irq_taken_reg, irq_taken_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic [8:0] mem_wdata_reg, mem_wdata_next;
  logic mem_we_reg, mem_we_next, mem_rd_reg, mem_rd_next;
  strobes_t strb_reg, strb_next;
  logic clk_out_reg, tty_reg, tty_next;
  logic strobing, strobe_done, cmd_wr;

  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    xfer_next = xfer_reg;
    ack_next = ack_reg;
    cur_next = cur_reg;
    end_next = end_reg;
    conc_en_next = conc_en_reg;
    irq_en_next = irq_en_reg;
    prio_en_next = prio_en_reg;
    stop_next = stop_reg;
    irq_id_next = irq_id_reg;
    irq_pend_next = irq_pend_reg;
    irq_taken_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_we_next = 1'b0;
    mem_rd_next = 1'b0;
    rdata_next = 16'h0000;
    strobing = mode_reg == MODE_CTRL || mode_reg == MODE_DOUT ||
               mode_reg == MODE_ACK || mode_reg == MODE_DIN;
    strobe_done = strobing && cnt_reg == LAST;
    cnt_next = (strobing && !strobe_done) ? cnt_reg + 3'h1 : 3'h0;
    cmd_wr = wr_en && addr == `REG_CMD;
    // Software writes
    if (wr_en)
    begin
      case (addr)
        `REG_CMD:
          if (state_reg == ST_IDLE)
          begin
            mode_next = io_mode_t'(wdata[`CMD_MODE_LSB +: 3]);
            if (wdata[`CMD_MODE_LSB +: 3] == MODE_CTRL || wdata[`CMD_MODE_LSB +: 3] == MODE_DOUT ||
                wdata[`CMD_MODE_LSB +: 3] == MODE_ACK || wdata[`CMD_MODE_LSB +: 3] == MODE_DIN)
              state_next = ST_SW;
          end
        `REG_XFER:
          if (state_reg == ST_IDLE)
            xfer_next = wdata[8:0] & DMASK;
        `REG_CUR: cur_next = wdata;
        `REG_END: end_next = wdata;
        `REG_CONC:
        begin
          conc_en_next = wdata[`CONC_EN_BIT];
          irq_en_next = wdata[`CONC_IRQ_EN_BIT];
          prio_en_next = wdata[`CONC_PRIO_BIT];
          stop_next = wdata[`CONC_STOP_LSB +: 3];
        end
        default: ;
      endcase
    end
    // Register reads; reading the identity clears its pending flag
    if (rd_en)
    begin
      case (addr)
        `REG_CMD: rdata_next = {9'h000, mode_reg, 3'h0, state_reg != ST_IDLE};
        `REG_XFER: rdata_next = {7'h00, xfer_reg};
        `REG_STATUS:
        begin
          rdata_next[`ST_IRQ_BIT] = irq_req;
          rdata_next[`ST_XFER_BIT] = xfer_req;
          rdata_next[`ST_PRIO_BIT] = prio_ret;
          rdata_next[`ST_BUSY_BIT] = state_reg != ST_IDLE;
        end
        `REG_ACK: rdata_next = {8'h00, ack_reg};
        `REG_CUR: rdata_next = cur_reg;
        `REG_END: rdata_next = end_reg;
        `REG_CONC: rdata_next = {8'h00, stop_reg, 2'h0, prio_en_reg, irq_en_reg, conc_en_reg};
        `REG_IRQ:
        begin
          rdata_next = {7'h00, irq_pend_reg, 2'h0, irq_id_reg};
          irq_pend_next = 1'b0;
        end
        default: rdata_next = 16'h0000;
      endcase
    end
    // Bus sequencer
    case (state_reg)
      ST_IDLE:
        if (!cmd_wr && conc_en_reg && xfer_req)
        begin
          mode_next = MODE_ACK;
          state_next = ST_CACK;
        end
        else if (!cmd_wr && irq_en_reg && irq_req && insn_boundary)
        begin
          mode_next = MODE_ACK;
          state_next = ST_IACK;
        end
      ST_SW:
        if (strobe_done)
        begin
          if (mode_reg == MODE_ACK)
            ack_next = in_data[7:0];
          if (mode_reg == MODE_DIN)
            xfer_next = in_data;
          mode_next = MODE_IDLE;
          state_next = ST_IDLE;
        end
      ST_CACK:
        if (strobe_done)
        begin
          ack_next = in_data[7:0];
          mode_next = MODE_IDLE;
          state_next = ST_CREL;
        end
      ST_CREL:
        if (!xfer_req)
        begin
          if (ack_reg[`ACK_OUT_BIT])
          begin
            mem_rd_next = 1'b1;
            mem_addr_next = cur_reg;
            state_next = ST_CFET;
          end
          else
          begin
            mode_next = MODE_DIN;
            state_next = ST_CDAT;
          end
        end
      ST_CFET:
      begin
        xfer_next = mem_rdata & DMASK;
        mode_next = MODE_DOUT;
        state_next = ST_CDAT;
      end
      ST_CDAT:
        if (strobe_done)
        begin
          if (mode_reg == MODE_DIN)
          begin
            mem_we_next = 1'b1;
            mem_addr_next = cur_reg;
            mem_wdata_next = in_data;
            xfer_next = in_data;
          end
          cur_next = cur_reg + 16'h0001;
          if (cur_reg + 16'h0001 == end_reg + 16'h0001)
          begin
            xfer_next = {1'b0, stop_reg, ack_reg[4:0]};
            mode_next = MODE_CTRL;
            state_next = ST_CSTOP;
          end
          else
          begin
            mode_next = MODE_IDLE;
            state_next = ST_IDLE;
          end
        end
      ST_CSTOP:
        if (strobe_done)
        begin
          if (!(wr_en && addr == `REG_CONC))
            conc_en_next = 1'b0;
          mode_next = MODE_IDLE;
          state_next = ST_IDLE;
        end
      ST_IACK:
        if (strobe_done)
        begin
          ack_next = in_data[7:0];
          irq_id_next = in_data[5:0];
          irq_pend_next = 1'b1;
          irq_taken_next = 1'b1;
          mode_next = MODE_IDLE;
        end
        // Stay until the released request is seen, or it would be taken twice
        else if (mode_reg == MODE_IDLE && !irq_req)
          state_next = ST_IDLE;
      default:
      begin
        mode_next = MODE_IDLE;
        state_next = ST_IDLE;
      end
    endcase
    strb_next.ctrl_n = mode_next != MODE_CTRL;
    strb_next.dout_n = mode_next != MODE_DOUT;
    strb_next.ack_n = mode_next != MODE_ACK;
    strb_next.din_n = mode_next != MODE_DIN;
    tty_next = mode_next != MODE_SPACE;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_IDLE;
      cnt_reg <= 3'h0;
      xfer_reg <= `RST_XFER;
      ack_reg <= 8'h00;
      cur_reg <= `RST_ADDR;
      end_reg <= `RST_ADDR;
      conc_en_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      prio_en_reg <= 1'b0;
      stop_reg <= `RST_STOP_ORDER;
      irq_id_reg <= 6'h00;
      irq_pend_reg <= 1'b0;
      irq_taken_reg <= 1'b0;
      mem_addr_reg <= `RST_ADDR;
      mem_wdata_reg <= 9'h000;
      mem_we_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      strb_reg <= 4'hf;
      clk_out_reg <= 1'b1;
      tty_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      xfer_reg <= xfer_next;
      ack_reg <= ack_next;
      cur_reg <= cur_next;
      end_reg <= end_next;
      conc_en_reg <= conc_en_next;
      irq_en_reg <= irq_en_next;
      prio_en_reg <= prio_en_next;
      stop_reg <= stop_next;
      irq_id_reg <= irq_id_next;
      irq_pend_reg <= irq_pend_next;
      irq_taken_reg <= irq_taken_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_we_reg <= mem_we_next;
      mem_rd_reg <= mem_rd_next;
      rdata_reg <= rdata_next;
      strb_reg <= strb_next;
      clk_out_reg <= ~clk_out_reg;
      tty_reg <= tty_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq_taken = irq_taken_reg;
  assign irq_id = irq_id_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_we = mem_we_reg;
  assign mem_rd = mem_rd_reg;
  assign out_bus_n = ~xfer_reg;
  assign ctrl_byte_strobe_n = strb_reg.ctrl_n;
  assign data_out_strobe_n = strb_reg.dout_n;
  assign ack_strobe_n = strb_reg.ack_n;
  assign data_in_strobe_n = strb_reg.din_n;
  assign bus_clock_out_n = clk_out_reg;
  assign priority_out_n = ~prio_en_reg;
  assign tty_line_on = tty_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_low4(sig);
    !sig [*4] ##1 sig;
  endsequence

  property p_ctrl_len;
    $fell(ctrl_byte_strobe_n) |-> s_low4(ctrl_byte_strobe_n);
  endproperty
  a_ctrl_len: assert property (p_ctrl_len)
    else $error("control strobe not four cycles");

  property p_din_len;
    $fell(data_in_strobe_n) |-> s_low4(data_in_strobe_n);
  endproperty
  a_din_len: assert property (p_din_len)
    else $error("data-in strobe not four cycles");

  property p_dout_len;
    $fell(data_out_strobe_n) |-> s_low4(data_out_strobe_n);
  endproperty
  a_dout_len: assert property (p_dout_len)
    else $error("data-out strobe not four cycles");

  property p_clk_half;
    bus_clock_out_n |=> !bus_clock_out_n ##1 bus_clock_out_n;
  endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("bus clock not half rate");

  property p_space;
    !tty_line_on |-> ctrl_byte_strobe_n && data_out_strobe_n && ack_strobe_n && data_in_strobe_n;
  endproperty
  a_space: assert property (p_space)
    else $error("bus activity in space mode");

  property p_stop;
    (state_reg == ST_CDAT && strobe_done && cur_reg == end_reg) |=>
      !ctrl_byte_strobe_n && cur_reg == $past(cur_reg) + 16'h0001;
  endproperty
  a_stop: assert property (p_stop)
    else $error("no stop byte after last address");

  property p_ctrl_fmt;
    (!ctrl_byte_strobe_n && state_reg == ST_CSTOP) |->
      ~out_bus_n[7:0] == {stop_reg, ack_reg[4:0]};
  endproperty
  a_ctrl_fmt: assert property (p_ctrl_fmt)
    else $error("stop byte format wrong");

  property p_release;
    (state_reg == ST_CREL && xfer_req) |=> data_in_strobe_n && data_out_strobe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("data strobe before request release");

  property p_boundary;
    ($fell(ack_strobe_n) && state_reg == ST_IACK) |-> $past(insn_boundary);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("interrupt taken inside instruction");

  property p_spare;
    (state_reg == ST_SW && mode_reg == MODE_DIN && strobe_done) |=>
      xfer_reg == $past(in_data) && (SPARE_BIT != 0 || !xfer_reg[8]);
  endproperty
  a_spare: assert property (p_spare)
    else $error("input byte not routed to transfer reg");

  property p_dout;
    ($fell(data_out_strobe_n) && state_reg == ST_CDAT) |->
      ~out_bus_n[7:0] == $past(mem_rdata[7:0]) && $past(mem_rd);
  endproperty
  a_dout: assert property (p_dout)
    else $error("output byte not fetched from memory");

  property p_idle;
    (state_reg == ST_SW && strobe_done) |=> mode_reg == MODE_IDLE;
  endproperty
  a_idle: assert property (p_idle)
    else $error("mode not back to idle");

  // No second acknowledge while the released request crosses the synchroniser
  property p_no_reack;
    irq_taken_reg |-> ack_strobe_n [*4];
  endproperty
  a_no_reack: assert property (p_no_reack)
    else $error("acknowledge repeated before request release");
endmodule : byte_io_bus

// file: rtl/byte_io_consts.svh
// Register offsets, field positions, reset values and counts of the byte I/O bus engine.
// Assumes inclusion by bare name from the engine and the testbench.
`ifndef BYTE_IO_CONSTS_SVH
`define BYTE_IO_CONSTS_SVH
`define REG_CMD 4'h0
`define REG_XFER 4'h1
`define REG_STATUS 4'h2
`define REG_ACK 4'h3
`define REG_CUR 4'h4
`define REG_END 4'h5
`define REG_CONC 4'h6
`define REG_IRQ 4'h7
`define CMD_MODE_LSB 4
`define ST_IRQ_BIT 7
`define ST_XFER_BIT 3
`define ST_PRIO_BIT 1
`define ST_BUSY_BIT 0
`define ACK_OUT_BIT 7
`define IRQ_PEND_BIT 8
`define CONC_EN_BIT 0
`define CONC_IRQ_EN_BIT 1
`define CONC_PRIO_BIT 2
`define CONC_STOP_LSB 5
`define STROBE_CYCLES 3'h4
`define RST_ADDR 16'h0000
`define RST_STOP_ORDER 3'h0
`define RST_XFER 9'h000
`define RST_LINES 12'hfff
`endif

// file: rtl/byte_io_pkg.sv
// Types shared by the byte I/O bus engine: modes, states and line groups.
// Assumes the constants header sits beside it.
package byte_io_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_CTRL = 3'h1,
    MODE_DOUT = 3'h2,
    MODE_SPACE = 3'h3,
    MODE_SP4 = 3'h4,
    MODE_ACK = 3'h5,
    MODE_DIN = 3'h6,
    MODE_SP7 = 3'h7
  } io_mode_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SW = 8'h02,
    ST_CACK = 8'h04,
    ST_CREL = 8'h08,
    ST_CFET = 8'h10,
    ST_CDAT = 8'h20,
    ST_CSTOP = 8'h40,
    ST_IACK = 8'h80
  } eng_state_t;

  typedef struct packed {
    logic ctrl_n;
    logic dout_n;
    logic ack_n;
    logic din_n;
  } strobes_t;

  typedef struct packed {
    logic irq_n;
    logic xfer_n;
    logic prio_n;
    logic [8:0] data_n;
  } in_lines_t;
endpackage : byte_io_pkg

// file: bench/bus_device.sv
// Peripheral device model for the byte I/O bus: priority, requests, ack byte, data bytes.
// Assumes terminated open-collector input lines that float high when released.
`timescale 1ns/1ps
module bus_device
  import byte_io_pkg::*;
(
  input wire logic ref_clk, // Processor clock
  input wire logic rst_n, // Async reset
  input wire logic prio_in_n, // Priority in
  input wire strobes_t strb, // Bus strobes
  input wire logic [8:0] out_bus_n, // Output bus
  input wire logic [4:0] my_num, // Device number
  input wire logic want_irq, // Wants an interrupt
  input wire logic want_xfer, // Wants byte transfers
  input wire logic out_flag, // Concurrent output
  input wire logic [5:0] ack_addr, // Acknowledge address
  input wire logic [8:0] in_data, // Byte to send
  output logic [8:0] in_bus_n, // Input bus
  output logic irq_n, // Interrupt request
  output logic xfer_n, // Transfer request
  output logic prio_out_n, // Priority out
  output logic [7:0] last_ctrl, // Last control byte
  output logic [8:0] last_dout, // Last data byte
  output int dout_cnt // Data bytes taken
);
  logic req, seen, sel, kind, dout_prev;
  logic [2:0] gap;
  wire want = want_irq | want_xfer;
  assign prio_out_n = prio_in_n | want;
  assign irq_n = ~(req & kind);
  assign xfer_n = ~(req & ~kind);
  always_comb
  begin
    in_bus_n = 9'h1ff;
    if (!strb.ack_n && req)
      in_bus_n = ~{1'b0, out_flag, 1'b0, ack_addr};
    else if (!strb.din_n && sel)
      in_bus_n = ~in_data;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {req, seen, sel, kind, dout_prev, gap} <= 8'h08;
      last_ctrl <= 8'h00;
      last_dout <= 9'h000;
      dout_cnt <= 0;
    end
    else
    begin
      dout_prev <= strb.dout_n;
      if (!strb.ctrl_n)
      begin
        last_ctrl <= ~out_bus_n[7:0];
        sel <= (~out_bus_n[4:0] == my_num);
      end
      if (!strb.dout_n && dout_prev && sel)
      begin
        last_dout <= ~out_bus_n;
        dout_cnt <= dout_cnt + 1;
      end
      if (gap != 3'h0)
        gap <= gap - 3'h1;
      if (!req && want && !prio_in_n && gap == 3'h0)
      begin
        req <= 1'b1;
        kind <= want_irq;
      end
      else if (req && !strb.ack_n)
        seen <= 1'b1;
      else if (req && seen)
      begin
        {req, seen} <= 2'h0;
        gap <= 3'h7;
      end
      else if (req && !want)
        req <= 1'b0;
    end
  end
endmodule : bus_device

// file: bench/testbench.sv
// Self-checking bench for the byte I/O bus engine with one peripheral device model.
// Assumes the engine built with the spare bit and a combinational memory model.
`timescale 1ns/1ps
`include "byte_io_consts.svh"
module testbench;
  import byte_io_pkg::*;
  typedef struct packed {io_mode_t mode; logic [8:0] xfer; strobes_t act; logic tty;} row_t;
  logic ref_clk, rst_n, wr_en, rd_en, insn_boundary, irq_taken, mem_we, mem_rd;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, mem_addr, d;
  logic [5:0] irq_id, ack_addr;
  logic [8:0] mem_wdata, in_bus_n, out_bus_n, dev_data, last_dout;
  logic ext_irq_req_n, xfer_request_n, priority_return_n, priority_out_n, tty_line_on;
  logic ctrl_byte_strobe_n, data_out_strobe_n, ack_strobe_n, data_in_strobe_n;
  logic bus_clock_out_n, want_irq, want_xfer, out_flag;
  logic [7:0] last_ctrl;
  int dout_cnt, base, togs, n_mismatch, n_compared;
  int lowc[4];
  strobes_t strb;
  row_t rows[8];
  wire [5:0] ev = {irq_taken, mem_we, strb};
  wire [8:0] mem_rdata = mem_rd ? (mem_addr[8:0] ^ 9'h0c3) : 9'h000;
  assign strb = {ctrl_byte_strobe_n, data_out_strobe_n, ack_strobe_n, data_in_strobe_n};

  byte_io_bus #(.SPARE_BIT(1)) byte_io_bus_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .insn_boundary(insn_boundary), .irq_taken(irq_taken), .irq_id(irq_id),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .in_bus_n(in_bus_n), .ext_irq_req_n(ext_irq_req_n),
    .xfer_request_n(xfer_request_n), .priority_return_n(priority_return_n),
    .out_bus_n(out_bus_n), .ctrl_byte_strobe_n(ctrl_byte_strobe_n),
    .data_out_strobe_n(data_out_strobe_n), .ack_strobe_n(ack_strobe_n),
    .data_in_strobe_n(data_in_strobe_n), .bus_clock_out_n(bus_clock_out_n),
    .priority_out_n(priority_out_n), .tty_line_on(tty_line_on));

  bus_device bus_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .prio_in_n(priority_out_n),
    .strb(strb), .out_bus_n(out_bus_n), .my_num(5'h05), .want_irq(want_irq),
    .want_xfer(want_xfer), .out_flag(out_flag), .ack_addr(ack_addr), .in_data(dev_data),
    .in_bus_n(in_bus_n), .irq_n(ext_irq_req_n), .xfer_n(xfer_request_n),
    .prio_out_n(priority_return_n), .last_ctrl(last_ctrl), .last_dout(last_dout),
    .dout_cnt(dout_cnt));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(what, v, rdata);
  endtask : rd_chk

  task automatic watch(input int n);
    logic prev;
    lowc = '{0, 0, 0, 0};
    togs = 0;
    #1;
    prev = bus_clock_out_n;
    repeat (n)
    begin
      for (int b = 0; b < 4; b++)
        if (strb[b] === 1'b0)
          lowc[b]++;
      @(posedge ref_clk);
      #1;
      if (bus_clock_out_n !== prev)
        togs++;
      prev = bus_clock_out_n;
    end
  endtask : watch

  task automatic wait_ev(input int i, input logic lvl);
    logic hit;
    hit = 1'b0;
    repeat (300)
    begin
      @(posedge ref_clk);
      #1;
      if (ev[i] === lvl)
      begin
        hit = 1'b1;
        break;
      end
    end
    if (!hit)
    begin
      n_mismatch++;
      $display("Error event %0d expected %b seen %b", i, lvl, ev[i]);
      give_verdict();
    end
  endtask : wait_ev

  task automatic give_verdict();
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    {rst_n, wr_en, rd_en, insn_boundary, want_irq, want_xfer, out_flag} = 7'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    ack_addr = 6'h05;
    dev_data = 9'h1e7;
    rows = '{'{MODE_CTRL, 9'h0a5, 4'h8, 1'b1}, '{MODE_DOUT, 9'h13c, 4'h4, 1'b1},
      '{MODE_ACK, 9'h011, 4'h2, 1'b1}, '{MODE_SPACE, 9'h022, 4'h0, 1'b0},
      '{MODE_SP4, 9'h033, 4'h0, 1'b1}, '{MODE_SP7, 9'h044, 4'h0, 1'b1},
      '{MODE_IDLE, 9'h055, 4'h0, 1'b1}, '{MODE_DIN, 9'h066, 4'h1, 1'b1}};
    repeat (4) @(posedge ref_clk);
    chk("reset strobes", 16'h000f, {12'h000, strb});
    chk("reset outputs", 16'h03ff, {6'h00, tty_line_on, out_bus_n});
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(`REG_XFER, {7'h00, rows[i].xfer});
      wr(`REG_CMD, {9'h000, rows[i].mode, 4'h0});
      watch(12);
      for (int b = 0; b < 4; b++)
        chk("strobe low cycles", rows[i].act[b] ? 16'h4 : 16'h0, 16'(lowc[b]));
      chk("bus clock toggles", 16'hc, 16'(togs));
      chk("tty line", {15'h0, rows[i].tty}, {15'h0, tty_line_on});
      if (rows[i].mode != MODE_DIN)
        chk("output bus", {7'h00, ~rows[i].xfer}, {7'h00, out_bus_n});
    end
    chk("control byte", 16'h00a5, {8'h00, last_ctrl});
    chk("data out byte", 16'h013c, {7'h00, last_dout});
    rd_chk("data in byte", `REG_XFER, 16'h01e7);
    rd_chk("unmapped", 4'h8, 16'h0000);
    wr(`REG_CONC, 16'h0004);
    repeat (5) @(posedge ref_clk);
    chk("priority out", 16'h0000, {15'h0, priority_out_n});
    rd_chk("status", `REG_STATUS, 16'h0002);
    wr(`REG_CUR, 16'h0100);
    wr(`REG_END, 16'h0101);
    dev_data <= 9'h0d2;
    want_xfer <= 1'b1;
    wr(`REG_CONC, 16'h00c5);
    wait_ev(4, 1'b1);
    chk("store address", 16'h0100, mem_addr);
    chk("store data", 16'h00d2, {7'h00, mem_wdata});
    dev_data <= 9'h13b;
    wait_ev(4, 1'b1);
    chk("store address", 16'h0101, mem_addr);
    chk("store data", 16'h013b, {7'h00, mem_wdata});
    wait_ev(3, 1'b0);
    wait_ev(3, 1'b1);
    want_xfer <= 1'b0;
    chk("stop byte", 16'h00c5, {8'h00, last_ctrl});
    rd_chk("conc reg", `REG_CONC, 16'h00c4);
    rd_chk("ack reg", `REG_ACK, 16'h0005);
    rd_chk("current address", `REG_CUR, 16'h0102);
    wr(`REG_CUR, 16'h0210);
    wr(`REG_END, 16'h0210);
    base = dout_cnt;
    out_flag <= 1'b1;
    want_xfer <= 1'b1;
    wr(`REG_CONC, 16'h0065);
    wait_ev(3, 1'b0);
    wait_ev(3, 1'b1);
    want_xfer <= 1'b0;
    chk("output count", 16'h1, 16'(dout_cnt - base));
    chk("output byte", 16'h00d3, {7'h00, last_dout});
    chk("fetch address", 16'h0210, mem_addr);
    chk("stop byte", 16'h0065, {8'h00, last_ctrl});
    rd_chk("ack reg", `REG_ACK, 16'h0085);
    rd_chk("current address", `REG_CUR, 16'h0211);
    out_flag <= 1'b0;
    ack_addr <= 6'h2a;
    want_irq <= 1'b1;
    wr(`REG_CONC, 16'h0006);
    watch(40);
    chk("ack inside instruction", 16'h0, 16'(lowc[1]));
    insn_boundary <= 1'b1;
    wait_ev(5, 1'b1);
    want_irq <= 1'b0;
    chk("irq identity", 16'h002a, {10'h000, irq_id});
    rd_chk("irq reg", `REG_IRQ, 16'h012a);
    rd_chk("irq reg cleared", `REG_IRQ, 16'h002a);
    give_verdict();
  end
endmodule : testbench
